// [msl_pkg.sv]
// Shared constants and state encoding for the memory sharing / legacy wrapper.
// Assumes a single 20 MHz system clock and an asynchronous active-high reset.
package msl_pkg;
	localparam int unsigned MSL_ADDR_W         = 16;
	localparam int unsigned MSL_DATA_W         = 16;
	localparam int unsigned MSL_MEM_AW         = 16;
	localparam logic [15:0] MSL_DATA_RST       = 16'h0000;
	localparam logic [15:0] MSL_ADDR_RST       = 16'h0000;
	localparam logic [15:0] MSL_BIT_RESULT_RST = 16'h0000;

	typedef enum logic [6:0] {
		MSL_IDLE     = 7'h01,
		MSL_REQ      = 7'h02,
		MSL_XFER     = 7'h04,
		MSL_DONE     = 7'h08,
		MSL_REL      = 7'h10,
		MSL_OWN_CORE = 7'h20,
		MSL_OWN_CPU  = 7'h40
	} msl_state_type;
endpackage

// [msl_mem.sv]
// Private synchronous memory used in own-memory mode.
// Assumes one access per cycle; read data appear one cycle after the enable.
module msl_mem #(
	parameter int unsigned AW = msl_pkg::MSL_MEM_AW,
	parameter int unsigned DW = msl_pkg::MSL_DATA_W
) (
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  wire logic          mem_en,
	input  wire logic          mem_we,
	input  wire logic [AW-1:0] mem_addr,
	input  wire logic [DW-1:0] mem_wdata,
	output logic      [DW-1:0] mem_rdata_q
);
	import msl_pkg::*;

	logic [DW-1:0] store [0:(1<<AW)-1];

	// Contents are never cleared or preloaded; software loads them before use [R11]
	always_ff @(posedge clk_sys) begin
		if (mem_en && mem_we) begin
			store[mem_addr] <= mem_wdata;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rdata_q <= '0;
		end else if (mem_en && !mem_we) begin
			mem_rdata_q <= store[mem_addr];
		end
	end
endmodule

// [msl_wrapper.sv]
// Memory attachment, arbitration and legacy single-bus wrapper.
// Assumes the 1553 logic holds core_req until core_ack and drops it on the next
// edge, and that the external arbiter and legacy host are synchronous to clk_sys.
// Overview of operation
// R1: In shared mode the block raises its memory request and only uses the bus after the grant.
// R2: The integrator ties own_memory_select low when the host memory bus is shared.
// R3: In own mode the block arbitrates its private memory between the 1553 logic and the host.
// R4: The integrator ties own_memory_select high when the block has a private memory.
// R5: Wiring the backend port straight to an on-chip synchronous memory is recommended only.
// R6: The wrapper merges host and memory buses onto one shared data bus through a small mux.
// R7: Address and data leave as separate input, output and enable ports, never bidirectional.
// R8: Shared data in is steered to memory or host data in, and its enable is the OR of both.
// R9: The host write strobe is low exactly when chip select and read/write are both low.
// R10: There is no buffer mode or self-test, yet the test result word is kept and returned.
// R11: Nothing is initialised automatically; software loads memory contents before use.
// R12: The request stays asserted for the whole access and the grant stays until it drops.
module msl_wrapper #(
	parameter int unsigned AW     = msl_pkg::MSL_ADDR_W,
	parameter int unsigned DW     = msl_pkg::MSL_DATA_W,
	parameter int unsigned MEM_AW = msl_pkg::MSL_MEM_AW
) (
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  wire logic          own_memory_select,
	input  wire logic          core_req,
	input  wire logic          core_we,
	input  wire logic [AW-1:0] core_addr,
	input  wire logic [DW-1:0] core_wdata,
	output logic               core_ack,
	output logic      [DW-1:0] core_rdata_q,
	input  wire logic          legacy_chip_select_low,
	input  wire logic          legacy_read_write_low,
	input  wire logic [AW-1:0] legacy_addr_in,
	input  wire logic [DW-1:0] shared_data_in,
	output logic      [DW-1:0] shared_data_out_q,
	output logic               shared_data_enable,
	output logic               host_write_strobe_low,
	output logic               host_ready_low,
	output logic               memory_request_low,
	input  wire logic          memory_grant_low,
	output logic      [AW-1:0] addr_out_q,
	output logic               addr_enable,
	output logic               mem_select_low,
	output logic               mem_read_low,
	output logic               mem_write_low,
	input  wire logic          bit_result_load,
	input  wire logic [DW-1:0] bit_result_value,
	input  wire logic          tx_bit_request,
	output logic      [DW-1:0] bit_word_q,
	output logic               bit_word_valid_q
);
	import msl_pkg::*;

	msl_state_type state_q;
	msl_state_type state_d;
	logic          shared_q;
	logic          owner_cpu_q;
	logic          fair_q;
	logic          cpu_served_q;
	logic [DW-1:0] bit_result_q;
	logic          cpu_req;
	logic          mem_en;
	logic          mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [DW-1:0] mem_wdata;
	logic [DW-1:0] mem_rdata;
	logic [DW-1:0] memory_data_in;
	logic [DW-1:0] host_data_in;
	logic          memory_data_drive_enable;
	logic          host_data_drive_enable;
	logic          req_active;

	assign cpu_req = !legacy_chip_select_low && !cpu_served_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MSL_IDLE: begin
				if (own_memory_select) begin
					if (core_req && (!cpu_req || fair_q)) begin
						state_d = MSL_OWN_CORE; // [R3]
					end else if (cpu_req) begin
						state_d = MSL_OWN_CPU; // [R3]
					end
				end else if (core_req) begin
					state_d = MSL_REQ; // [R1]
				end
			end
			MSL_REQ: begin
				if (!memory_grant_low) begin
					state_d = MSL_XFER; // [R1]
				end
			end
			MSL_XFER:     state_d = MSL_DONE;
			MSL_OWN_CORE: state_d = MSL_DONE;
			MSL_OWN_CPU:  state_d = MSL_DONE;
			MSL_DONE:     state_d = shared_q ? MSL_REL : MSL_IDLE;
			MSL_REL: begin
				// Wait for the arbiter to drop its grant before a new request
				if (memory_grant_low) begin
					state_d = MSL_IDLE; // [R12]
				end
			end
			default: state_d = MSL_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= MSL_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Mode is sampled only between accesses so a strap change cannot split a cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shared_q    <= 1'b0;
			owner_cpu_q <= 1'b0;
			fair_q      <= 1'b0;
		end else if (state_q == MSL_IDLE) begin
			shared_q    <= !own_memory_select;
			owner_cpu_q <= (state_d == MSL_OWN_CPU);
			if (state_d == MSL_OWN_CPU || state_d == MSL_OWN_CORE) begin
				fair_q <= (state_d == MSL_OWN_CPU); // [R3]
			end
		end
	end

	// Host must release chip select before its next access is taken
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cpu_served_q <= 1'b0;
		end else if (legacy_chip_select_low) begin
			cpu_served_q <= 1'b0;
		end else if (state_q == MSL_DONE && owner_cpu_q) begin
			cpu_served_q <= 1'b1;
		end
	end

	// Demux of the single data input [R8]
	assign memory_data_in = (state_q == MSL_DONE && shared_q) ? shared_data_in : '0;
	assign host_data_in   = (state_q == MSL_OWN_CPU) ? shared_data_in : '0;

	assign mem_en    = (state_q == MSL_OWN_CORE) || (state_q == MSL_OWN_CPU);
	assign mem_we    = (state_q == MSL_OWN_CORE) ? core_we : !legacy_read_write_low;
	assign mem_addr  = (state_q == MSL_OWN_CORE) ? MEM_AW'(core_addr) : MEM_AW'(legacy_addr_in);
	assign mem_wdata = (state_q == MSL_OWN_CORE) ? core_wdata : host_data_in;

	msl_mem #(
		.AW (MEM_AW),
		.DW (DW)
	) u_mem (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.mem_en      (mem_en),
		.mem_we      (mem_we),
		.mem_addr    (mem_addr),
		.mem_wdata   (mem_wdata),
		.mem_rdata_q (mem_rdata)
	);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			core_rdata_q <= MSL_DATA_RST;
		end else if (state_q == MSL_DONE && !owner_cpu_q) begin
			core_rdata_q <= shared_q ? memory_data_in : mem_rdata;
		end
	end

	// One register feeds the shared data output for both buses [R6]
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shared_data_out_q <= MSL_DATA_RST;
			addr_out_q        <= MSL_ADDR_RST;
		end else if (state_q == MSL_REQ && !memory_grant_low) begin
			shared_data_out_q <= core_wdata; // [R6]
			addr_out_q        <= core_addr; // [R7]
		end else if (state_q == MSL_DONE && owner_cpu_q) begin
			shared_data_out_q <= mem_rdata; // [R6]
		end
	end

	assign core_ack       = (state_q == MSL_DONE) && !owner_cpu_q;
	assign host_ready_low = !((state_q == MSL_DONE) && owner_cpu_q);

	assign req_active         = (state_q == MSL_REQ) || (state_q == MSL_XFER)
		|| ((state_q == MSL_DONE) && shared_q);
	assign memory_request_low = !req_active; // [R12]

	// Separate enables replace any bidirectional pin [R7]
	assign addr_enable    = (state_q == MSL_XFER);
	assign mem_select_low = !(state_q == MSL_XFER);
	assign mem_read_low   = !((state_q == MSL_XFER) && !core_we);
	assign mem_write_low  = !((state_q == MSL_XFER) && core_we);

	assign memory_data_drive_enable = (state_q == MSL_XFER) && core_we;
	assign host_data_drive_enable   = !legacy_chip_select_low && legacy_read_write_low
		&& cpu_served_q;
	assign shared_data_enable = memory_data_drive_enable || host_data_drive_enable; // [R8]

	assign host_write_strobe_low = !(!legacy_chip_select_low && !legacy_read_write_low); // [R9]

	// Only a stored result word; no self-test sequence exists to refresh it
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bit_result_q <= MSL_BIT_RESULT_RST;
		end else if (bit_result_load) begin
			bit_result_q <= bit_result_value; // [R10]
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bit_word_q       <= MSL_DATA_RST;
			bit_word_valid_q <= 1'b0;
		end else begin
			bit_word_valid_q <= tx_bit_request; // [R10]
			if (tx_bit_request) begin
				bit_word_q <= bit_result_q;
			end
		end
	end

	sequence s_grant_seen;
		(state_q == MSL_REQ) && !memory_grant_low;
	endsequence

	sequence s_bus_cycle;
		addr_enable ##1 (core_ack && !memory_request_low);
	endsequence

	property p_grant_then_cycle;
		@(posedge clk_sys) disable iff (sys_rst)
		s_grant_seen |=> s_bus_cycle;
	endproperty
	a_grant_then_cycle: assert property (p_grant_then_cycle) // [R1]
		else $error("bus cycle did not follow the grant");

	property p_no_bus_without_grant;
		@(posedge clk_sys) disable iff (sys_rst)
		addr_enable |-> ($past(state_q) == MSL_REQ) && !$past(memory_grant_low)
			&& (shared_data_out_q[0] == $past(core_wdata[0]));
	endproperty
	a_no_bus_without_grant: assert property (p_no_bus_without_grant) // [R1]
		else $error("memory bus driven without a grant");

	property p_own_core_served;
		@(posedge clk_sys) disable iff (sys_rst)
		(state_q == MSL_IDLE && own_memory_select && core_req && !cpu_req)
			|-> ##2 core_ack && memory_request_low;
	endproperty
	a_own_core_served: assert property (p_own_core_served) // [R3]
		else $error("private memory access by 1553 logic not served in two cycles");

	property p_own_cpu_served;
		@(posedge clk_sys) disable iff (sys_rst)
		(state_q == MSL_IDLE && own_memory_select && cpu_req && !core_req) |-> ##2 !host_ready_low;
	endproperty
	a_own_cpu_served: assert property (p_own_cpu_served) // [R3]
		else $error("host access to private memory not served in two cycles");

	property p_host_read_data;
		@(posedge clk_sys) disable iff (sys_rst)
		(!host_ready_low && legacy_read_write_low) |=> shared_data_out_q == $past(mem_rdata);
	endproperty
	a_host_read_data: assert property (p_host_read_data) // [R6]
		else $error("host read data not placed on shared output");

	property p_enable_or;
		@(posedge clk_sys) disable iff (sys_rst)
		shared_data_enable == (!mem_write_low
			|| (!legacy_chip_select_low && legacy_read_write_low && cpu_served_q));
	endproperty
	a_enable_or: assert property (p_enable_or) // [R8]
		else $error("shared data enable is not the OR of both enables");

	property p_write_strobe;
		@(posedge clk_sys) disable iff (sys_rst)
		host_write_strobe_low == (legacy_chip_select_low || legacy_read_write_low);
	endproperty
	a_write_strobe: assert property (p_write_strobe) // [R9]
		else $error("host write strobe does not follow chip select and read/write");

	property p_bit_word;
		@(posedge clk_sys) disable iff (sys_rst)
		tx_bit_request |=> bit_word_valid_q && (bit_word_q == $past(bit_result_q));
	endproperty
	a_bit_word: assert property (p_bit_word) // [R10]
		else $error("test result word not returned one cycle after request");

	property p_request_held;
		@(posedge clk_sys) disable iff (sys_rst)
		s_grant_seen |=> !memory_request_low [*2] ##1 memory_request_low;
	endproperty
	a_request_held: assert property (p_request_held) // [R12]
		else $error("memory request not held for the whole access");
endmodule

// [msl_arbiter_model.sv]
// Model of the external bus arbiter plus synchronous memory on the backend port.
// Assumes the wrapper drives strobes for one cycle; read data follow one cycle later.
module msl_arbiter_model (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        slow_grant,
	input  wire logic        memory_request_low,
	output logic             memory_grant_low,
	input  wire logic [15:0] addr_out_q,
	input  wire logic        mem_select_low,
	input  wire logic        mem_read_low,
	input  wire logic        mem_write_low,
	input  wire logic [15:0] shared_data_out_q,
	output logic      [15:0] read_data
);
	logic [15:0] mem [0:255];
	logic [3:0]  wait_q;

	// Grant after a wait only when slow_grant is set, and held until the request is withdrawn
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wait_q <= 4'h0;
			memory_grant_low <= 1'b1;
		end else if (memory_request_low) begin
			wait_q <= 4'h0;
			memory_grant_low <= 1'b1;
		end else begin
			wait_q <= wait_q + 4'h1;
			if (wait_q >= (slow_grant ? 4'h5 : 4'h0))
				memory_grant_low <= 1'b0;
		end
	end

	// Synchronous block wired straight to the backend; idle data toggle so stale values never pass
	always_ff @(posedge clk_sys) begin
		if (!mem_select_low && !mem_write_low)
			mem[addr_out_q[7:0]] <= shared_data_out_q;
		if (!mem_select_low && !mem_read_low)
			read_data <= mem[addr_out_q[7:0]];
		else
			read_data <= ~read_data;
	end
endmodule

// [tb_memory_sharing_legacy_wrapper.sv]
// Self-checking bench for the memory sharing / legacy wrapper.
// Assumes the arbiter model above; host and memory share the single data input.
module tb_memory_sharing_legacy_wrapper;
	timeunit 1ns;
	timeprecision 100ps;
	import msl_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic own_memory_select = 1'b0;
	logic core_req = 1'b0, core_we = 1'b0, slow_grant = 1'b0;
	logic [15:0] core_addr = 16'h0000, core_wdata = 16'h0000, legacy_addr_in = 16'h0000;
	logic legacy_chip_select_low = 1'b1, legacy_read_write_low = 1'b1;
	logic bit_result_load = 1'b0, tx_bit_request = 1'b0, host_drv = 1'b0;
	logic [15:0] bit_result_value = 16'h0000, host_data = 16'h0000, model_data;
	logic [15:0] shared_data_in, core_rdata_q, shared_data_out_q, addr_out_q, bit_word_q;
	logic core_ack, shared_data_enable, host_write_strobe_low, host_ready_low;
	logic memory_request_low, memory_grant_low, addr_enable, mem_select_low;
	logic mem_read_low, mem_write_low, bit_word_valid_q;
	int fails = 0;
	int checked = 0;
	time t_core, t_host;
	logic [15:0] rd, rd2;

	assign shared_data_in = host_drv ? host_data : model_data;
	always #25 clk_sys = ~clk_sys;

	msl_wrapper #(.MEM_AW(8)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.own_memory_select(own_memory_select), .core_req(core_req), .core_we(core_we),
		.core_addr(core_addr), .core_wdata(core_wdata), .core_ack(core_ack),
		.core_rdata_q(core_rdata_q), .legacy_chip_select_low(legacy_chip_select_low),
		.legacy_read_write_low(legacy_read_write_low), .legacy_addr_in(legacy_addr_in),
		.shared_data_in(shared_data_in), .shared_data_out_q(shared_data_out_q),
		.shared_data_enable(shared_data_enable), .host_write_strobe_low(host_write_strobe_low),
		.host_ready_low(host_ready_low), .memory_request_low(memory_request_low),
		.memory_grant_low(memory_grant_low), .addr_out_q(addr_out_q), .addr_enable(addr_enable),
		.mem_select_low(mem_select_low), .mem_read_low(mem_read_low),
		.mem_write_low(mem_write_low), .bit_result_load(bit_result_load),
		.bit_result_value(bit_result_value), .tx_bit_request(tx_bit_request),
		.bit_word_q(bit_word_q), .bit_word_valid_q(bit_word_valid_q));

	msl_arbiter_model partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow_grant(slow_grant),
		.memory_request_low(memory_request_low), .memory_grant_low(memory_grant_low),
		.addr_out_q(addr_out_q), .mem_select_low(mem_select_low), .mem_read_low(mem_read_low),
		.mem_write_low(mem_write_low), .shared_data_out_q(shared_data_out_q),
		.read_data(model_data));

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Called at a falling edge; request and qualifiers held until the acknowledge
	task automatic core_xfer(input logic we, input logic [15:0] a, d, output logic [15:0] r);
		int n;
		core_req = 1'b1;
		core_we = we;
		core_addr = a;
		core_wdata = d;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
			if (!own_memory_select) begin
				check("request_low", 16'h0, {15'h0, memory_request_low});
				if (memory_grant_low === 1'b1) check("early_enable", 16'h0, {15'h0, addr_enable});
				if (addr_enable === 1'b1) check("addr_out", a, addr_out_q);
				if (addr_enable === 1'b1 && we) check("data_out", d, shared_data_out_q);
				if (addr_enable === 1'b1) check("data_en", {15'h0, we}, {15'h0, shared_data_enable});
				if (addr_enable === 1'b1) check("strobes", {13'h0, 1'b0, we, ~we},
					{13'h0, mem_select_low, mem_read_low, mem_write_low});
			end
		end while (core_ack !== 1'b1 && n < 40);
		t_core = $time;
		check("core_ack", 16'h1, {15'h0, core_ack});
		core_req = 1'b0;
		@(negedge clk_sys);
		r = core_rdata_q;
		n = 0;
		while ((memory_request_low !== 1'b1 || memory_grant_low !== 1'b1) && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		check("released", 16'h1, {15'h0, memory_request_low & memory_grant_low});
		@(negedge clk_sys);
	endtask

	task automatic host_xfer(input logic we, input logic [15:0] a, d, output logic [15:0] r);
		int n;
		legacy_chip_select_low = 1'b0;
		legacy_read_write_low = ~we;
		legacy_addr_in = a;
		host_data = d;
		host_drv = we;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (host_ready_low !== 1'b0 && n < 40);
		t_host = $time;
		check("host_ready", 16'h0, {15'h0, host_ready_low});
		@(negedge clk_sys);
		r = shared_data_out_q;
		if (!we) check("host_den", 16'h1, {15'h0, shared_data_enable});
		legacy_chip_select_low = 1'b1;
		legacy_read_write_low = 1'b1;
		host_drv = 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic test_strobe();
		for (int i = 0; i < 4; i++) begin
			legacy_chip_select_low = i[1];
			legacy_read_write_low = i[0];
			#5 check("write_strobe", {15'h0, (i != 0)}, {15'h0, host_write_strobe_low});
			@(negedge clk_sys);
		end
		legacy_chip_select_low = 1'b1;
		legacy_read_write_low = 1'b1;
		repeat (3) @(negedge clk_sys);
		$display("test strobe done");
	endtask

	task automatic test_shared();
		for (int s = 0; s < 2; s++) begin
			slow_grant = s[0];
			core_xfer(1'b1, 16'h0011 + 16'(s), 16'hA5C3 ^ 16'(s), rd);
			core_xfer(1'b0, 16'h0011 + 16'(s), 16'h0000, rd);
			check("shared_read", 16'hA5C3 ^ 16'(s), rd);
		end
		$display("test shared done");
	endtask

	task automatic test_own();
		own_memory_select = 1'b1;
		core_xfer(1'b1, 16'h0022, 16'h1234, rd);
		host_xfer(1'b0, 16'h0022, 16'h0000, rd);
		check("host_read", 16'h1234, rd);
		host_xfer(1'b1, 16'h0033, 16'hBEEF, rd);
		core_xfer(1'b0, 16'h0033, 16'h0000, rd);
		check("core_read", 16'hBEEF, rd);
		// Contention: the first tie goes to the host
		fork
			core_xfer(1'b0, 16'h0022, 16'h0000, rd2);
			host_xfer(1'b0, 16'h0033, 16'h0000, rd);
		join
		check("host_first", 16'h1, {15'h0, (t_host < t_core)});
		check("tie_core", 16'h1234, rd2);
		check("tie_host", 16'hBEEF, rd);
		// After a lone host access the next tie goes to the 1553 logic
		host_xfer(1'b1, 16'h0044, 16'h5A5A, rd);
		fork
			core_xfer(1'b0, 16'h0044, 16'h0000, rd2);
			host_xfer(1'b0, 16'h0022, 16'h0000, rd);
		join
		check("core_first", 16'h1, {15'h0, (t_core < t_host)});
		check("tie2_core", 16'h5A5A, rd2);
		check("tie2_host", 16'h1234, rd);
		check("no_request", 16'h1, {15'h0, memory_request_low});
		own_memory_select = 1'b0;
		$display("test own done");
	endtask

	task automatic test_bit();
		bit_result_load = 1'b1;
		bit_result_value = 16'hC0DE;
		@(negedge clk_sys);
		bit_result_load = 1'b0;
		tx_bit_request = 1'b1;
		@(negedge clk_sys);
		check("bit_valid", 16'h1, {15'h0, bit_word_valid_q});
		check("bit_word", 16'hC0DE, bit_word_q);
		tx_bit_request = 1'b0;
		@(negedge clk_sys);
		check("bit_pulse", 16'h0, {15'h0, bit_word_valid_q});
		$display("test bit done");
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		check("reset_req", 16'h1, {15'h0, memory_request_low});
		test_strobe();
		test_shared();
		test_own();
		test_bit();
		conclude();
	end

	// Whole run is about a hundred cycles; this 2000-cycle span leaves a wide margin
	initial begin
		#100us;
		fails++;
		conclude();
	end
endmodule
